//--- hdl/ata_cmd_pkg.sv
// package: constants, types and timer decode for the idle and geometry command block
package ata_cmd_pkg;

	// command opcodes
	localparam logic [7:0] OP_IDLE_A      = 8'he3;
	localparam logic [7:0] OP_IDLE_B      = 8'h97;
	localparam logic [7:0] OP_IDLE_IMM_A  = 8'he1;
	localparam logic [7:0] OP_IDLE_IMM_B  = 8'h95;
	localparam logic [7:0] OP_INIT_PARAMS = 8'h91;

	// register byte offsets on the avalon slave
	localparam logic [7:0] OFS_SECTOR_COUNT   = 8'h00;
	localparam logic [7:0] OFS_DEVICE_HEAD    = 8'h04;
	localparam logic [7:0] OFS_COMMAND        = 8'h08;
	localparam logic [7:0] OFS_ERROR_FLAGS    = 8'h0c;
	localparam logic [7:0] OFS_COMMAND_STATUS = 8'h10;
	localparam logic [7:0] OFS_FEATURE_OPT    = 8'h14;
	localparam logic [7:0] OFS_GEOMETRY       = 8'h18;
	localparam logic [7:0] OFS_POWER          = 8'h1c;
	localparam logic [7:0] OFS_IDENT_SUM      = 8'h20;
	localparam logic [7:0] OFS_IDENT_W129     = 8'h24;
	localparam logic [7:0] OFS_IDENT_W255     = 8'h28;
	localparam logic [7:0] OFS_IRQ_STATUS     = 8'h2c;
	localparam logic [7:0] OFS_IRQ_CLEAR      = 8'h30;
	localparam logic [7:0] OFS_IRQ_ENABLE     = 8'h34;
	localparam logic [7:0] OFS_SOFT_RESET     = 8'h38;
	localparam logic [7:0] OFS_HOST_ACCESS    = 8'h3c;

	// field positions
	localparam int ST_BSY_BIT  = 7;
	localparam int ST_RDY_BIT  = 6;
	localparam int ST_DSC_BIT  = 4;
	localparam int ST_ERR_BIT  = 0;
	localparam int ERR_ABT_BIT = 2;
	localparam int OPT_REVERT_BIT = 2;
	localparam int IRQ_DONE_BIT    = 0;
	localparam int IRQ_ABORT_BIT   = 1;
	localparam int IRQ_STANDBY_BIT = 2;
	localparam int IRQ_W = 3;

	// values after reset, and the identify signature
	localparam logic [7:0] RST_SPT       = 8'h3f;
	localparam logic [3:0] RST_HEADS_M1  = 4'hf;
	localparam logic [3:0] RST_FEAT_OPT  = 4'h0;
	localparam logic [7:0] ID_SIGNATURE  = 8'ha5;

	// timer: every interval is a whole number of 5 s ticks
	localparam int CLK_HZ            = 50_000_000;
	localparam int TIMER_UNIT_S      = 5;
	localparam int TIMER_UNIT_CYCLES = CLK_HZ * TIMER_UNIT_S;
	localparam logic [7:0]  TMO_LINEAR_MAX = 8'd240;
	localparam logic [7:0]  TMO_HALFHR_MAX = 8'd251;
	localparam logic [15:0] TICKS_HALF_HOUR = 16'h0168;
	localparam logic [15:0] TICKS_21M       = 16'h00fc;
	localparam logic [15:0] TICKS_8H        = 16'h1680;
	localparam logic [15:0] TICKS_21M10S    = 16'h00fe;
	localparam logic [15:0] TICKS_21M15S    = 16'h00ff;

	typedef enum logic [1:0] {
		ST_READY = 2'b00,
		ST_EXEC  = 2'b01,
		ST_SPIN  = 2'b10,
		ST_DONE  = 2'b11
	} cmd_state_e;

	typedef enum logic [1:0] {
		PWR_STANDBY = 2'b00,
		PWR_IDLE    = 2'b01
	} pwr_mode_e;

	typedef struct packed {
		logic [3:0] heads_m1;
		logic [7:0] spt;
	} geometry_s;

	// sector count value to 5 s ticks
	function automatic logic [15:0] timeout_ticks(input logic [7:0] v);
		logic [15:0] t;
		t = 16'h0000;
		if (v <= TMO_LINEAR_MAX) begin
			t = {8'h00, v};
		end else if (v <= TMO_HALFHR_MAX) begin
			t = 16'((v - TMO_LINEAR_MAX) * TICKS_HALF_HOUR);
		end else begin
			case (v[1:0])
				2'b00:   t = TICKS_21M;
				2'b01:   t = TICKS_8H;
				2'b10:   t = TICKS_21M10S;
				default: t = TICKS_21M15S;
			endcase
		end
		return t;
	endfunction

endpackage

//--- hdl/ata_idle_geom.sv
// idle, idle immediate and geometry command handling with standby timer and identify words
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps

// Contract
// [RQ1] idle opcode: enter idle, load, start timer
// [RQ2] spin up unless spindle already at speed
// [RQ3] zero timer value disables auto standby
// [RQ4] 1-240 times 5 s; 241-251 half hours
// [RQ5] 252..255 decode to fixed special intervals
// [RQ6] expiry without host access enters standby
// [RQ7] host access restarts full interval
// [RQ8] idle immediate keeps stored timer value
// [RQ9] idle keeps spindle at speed, ready
// [RQ10] geometry command stores sectors and heads
// [RQ11] zero sectors per track means zero
// [RQ12] head field holds heads minus one, 0-15
// [RQ13] geometry holds unless reverting reset
// [RQ14] host picks geometry with legal cylinders
// [RQ15] word 129 reports current feature options
// [RQ16] word 255: checksum high, signature low
// [RQ17] bad command aborts; busy clears at end
module ata_idle_geom import ata_cmd_pkg::*; #(
	parameter int TICK_CYCLES = TIMER_UNIT_CYCLES
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// drive pins
	input  wire logic        spindle_at_speed,
	input  wire logic        hard_reset_n,
	output logic             spindle_run,
	output logic             irq
);

	cmd_state_e  state;
	pwr_mode_e   pwr;
	geometry_s   geom;
	logic [7:0]  sector_count;
	logic [7:0]  device_head;
	logic [7:0]  opcode;
	logic [7:0]  cmd_sc;
	logic [3:0]  cmd_head;
	logic [7:0]  error_flags;
	logic        err;
	logic [3:0]  feat_opt;
	logic [31:0] ident_sum;
	logic [15:0] standby_reload;
	logic [15:0] standby_left;
	logic [27:0] presc;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_enable;
	logic [IRQ_W-1:0] irq_set;
	logic        speed_meta, speed_s;
	logic        hrst_meta, hrst_s;
	logic        bus_wr, bus_rd_take, host_access, reset_evt;
	logic        cmd_go, op_idle, op_imm, op_init, tick, expire;
	logic [7:0]  command_status;
	logic [15:0] word129, word255;
	logic [7:0]  cksum;
	logic [31:0] next_readdata;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// pins cross into ref_clk through two flops
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			speed_meta <= 1'b0;
			speed_s    <= 1'b0;
			hrst_meta  <= 1'b1;
			hrst_s     <= 1'b1;
		end else begin
			speed_meta <= spindle_at_speed;
			speed_s    <= speed_meta;
			hrst_meta  <= hard_reset_n;
			hrst_s     <= hrst_meta;
		end
	end

	// one wait cycle per access: writes taken at the edge where waitrequest is seen low, read data captured at the edge before
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	assign bus_wr      = avs_write && !avs_waitrequest;
	assign bus_rd_take = avs_read && avs_waitrequest;
	assign cmd_go      = bus_wr && avs_address == OFS_COMMAND && avs_byteenable[0] && state == ST_READY;
	assign host_access = cmd_go || (bus_wr && avs_address == OFS_HOST_ACCESS);
	assign reset_evt   = !hrst_s || (bus_wr && avs_address == OFS_SOFT_RESET);
	assign op_idle     = opcode == OP_IDLE_A || opcode == OP_IDLE_B;
	assign op_imm      = opcode == OP_IDLE_IMM_A || opcode == OP_IDLE_IMM_B;
	assign op_init     = opcode == OP_INIT_PARAMS;
	assign tick        = presc == 28'(TICK_CYCLES - 1);
	assign expire      = pwr == PWR_IDLE && standby_reload != 16'h0000 && standby_left == 16'h0000; // RQ3 RQ6

	// task file registers written by the host
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sector_count <= 8'h00;
			device_head  <= 8'h00;
			feat_opt     <= RST_FEAT_OPT;
			ident_sum    <= 32'h0000_0000;
			irq_enable   <= '0;
		end else if (bus_wr) begin
			case (avs_address)
				// narrow registers live in lane 0 only
				OFS_SECTOR_COUNT: begin
					if (avs_byteenable[0]) begin
						sector_count <= avs_writedata[7:0];
					end
				end
				OFS_DEVICE_HEAD: begin
					if (avs_byteenable[0]) begin
						device_head <= avs_writedata[7:0];
					end
				end
				OFS_FEATURE_OPT: begin
					if (avs_byteenable[0]) begin
						feat_opt <= avs_writedata[3:0];
					end
				end
				OFS_IDENT_SUM:    ident_sum    <= merge(ident_sum, avs_writedata, avs_byteenable);
				OFS_IRQ_ENABLE: begin
					if (avs_byteenable[0]) begin
						irq_enable <= avs_writedata[IRQ_W-1:0];
					end
				end
				default: ;
			endcase
		end
	end

	// command sequencer; writes to the command register while busy are dropped
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state    <= ST_READY;
			opcode   <= 8'h00;
			cmd_sc   <= 8'h00;
			cmd_head <= 4'h0;
		end else if (reset_evt) begin
			state <= ST_READY;
		end else begin
			case (state)
				ST_READY: begin
					if (cmd_go) begin
						opcode   <= avs_writedata[7:0];
						cmd_sc   <= sector_count;
						cmd_head <= device_head[3:0]; // RQ12
						state    <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					if ((op_idle || op_imm) && !speed_s) begin
						state <= ST_SPIN; // RQ2
					end else begin
						state <= ST_DONE; // RQ2 RQ9
					end
				end
				ST_SPIN: begin
					if (speed_s) begin
						state <= ST_DONE;
					end
				end
				ST_DONE: state <= ST_READY; // RQ17
				default: state <= ST_READY;
			endcase
		end
	end

	// error and error status, cleared when a new command starts
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			error_flags <= 8'h00;
			err         <= 1'b0;
		end else if (cmd_go) begin
			error_flags <= 8'h00;
			err         <= 1'b0;
		end else if (state == ST_EXEC && !(op_idle || op_imm || op_init)) begin
			error_flags[ERR_ABT_BIT] <= 1'b1; // RQ17
			err                      <= 1'b1; // RQ17
		end
	end

	// power mode and spindle drive
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwr         <= PWR_STANDBY;
			spindle_run <= 1'b0;
		end else if (state == ST_EXEC && (op_idle || op_imm)) begin
			pwr         <= PWR_IDLE; // RQ1 RQ8
			spindle_run <= 1'b1;     // RQ2 RQ9
		end else if (expire && state == ST_READY && !host_access) begin
			pwr         <= PWR_STANDBY; // RQ6
			spindle_run <= 1'b0;
		end
	end

	// standby timer; prescaler only runs while a countdown is live
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			standby_reload <= 16'h0000;
			standby_left   <= 16'h0000;
			presc          <= 28'h0000000;
		end else if (state == ST_EXEC && op_idle) begin
			standby_reload <= timeout_ticks(cmd_sc); // RQ1 RQ4 RQ5
			standby_left   <= timeout_ticks(cmd_sc); // RQ1
			presc          <= 28'h0000000;
		end else if (host_access) begin
			standby_left <= standby_reload; // RQ7
			presc        <= 28'h0000000;
		end else if (pwr == PWR_IDLE && standby_left != 16'h0000) begin
			presc <= tick ? 28'h0000000 : presc + 28'h0000001;
			if (tick) begin
				standby_left <= standby_left - 16'h0001;
			end
		end
	end

	// geometry is kept across hard and soft resets unless the reverting option is enabled; rst always reloads it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			geom.spt      <= RST_SPT;
			geom.heads_m1 <= RST_HEADS_M1;
		end else if (reset_evt) begin
			if (feat_opt[OPT_REVERT_BIT]) begin
				geom.spt      <= RST_SPT; // RQ13
				geom.heads_m1 <= RST_HEADS_M1;
			end
		end else if (state == ST_EXEC && op_init) begin
			geom.spt      <= cmd_sc;   // RQ10 RQ11
			geom.heads_m1 <= cmd_head; // RQ10
		end
	end

	// identify words; ident_sum carries all bytes 0..509 except words 55, 56 and 129
	assign word129 = {12'h000, feat_opt}; // RQ15
	assign cksum   = 8'(8'h00 - (ident_sum[7:0] + {4'h0, geom.heads_m1} + 8'h01 + geom.spt
	                 + {4'h0, feat_opt} + ID_SIGNATURE));
	assign word255 = {cksum, ID_SIGNATURE}; // RQ16

	always_comb begin
		command_status = 8'h00;
		command_status[ST_BSY_BIT] = state != ST_READY; // RQ17
		command_status[ST_RDY_BIT] = state == ST_READY;
		command_status[ST_DSC_BIT] = speed_s;
		command_status[ST_ERR_BIT] = err;
	end

	// sticky interrupt status, a set in the clear cycle wins
	assign irq_set = {expire && state == ST_READY && !host_access && pwr == PWR_IDLE,
	                  state == ST_DONE && err, state == ST_DONE};

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_status <= '0;
		end else if (bus_wr && avs_address == OFS_IRQ_CLEAR) begin
			irq_status <= (irq_status & ~avs_writedata[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_status <= irq_status | irq_set;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_enable);
		end
	end

	// read mux; unmapped and write-only offsets read zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		case (avs_address)
			OFS_SECTOR_COUNT:   next_readdata = {24'h0, sector_count};
			OFS_DEVICE_HEAD:    next_readdata = {24'h0, device_head};
			OFS_ERROR_FLAGS:    next_readdata = {24'h0, error_flags};
			OFS_COMMAND_STATUS: next_readdata = {24'h0, command_status};
			OFS_FEATURE_OPT:    next_readdata = {28'h0, feat_opt};
			OFS_GEOMETRY:       next_readdata = {20'h0, geom};
			OFS_POWER:          next_readdata = {standby_left, 7'h00, standby_reload != 16'h0000, 6'h00, pwr};
			OFS_IDENT_SUM:      next_readdata = ident_sum;
			OFS_IDENT_W129:     next_readdata = {16'h0, word129};
			OFS_IDENT_W255:     next_readdata = {16'h0, word255};
			OFS_IRQ_STATUS:     next_readdata = {29'h0, irq_status};
			OFS_IRQ_ENABLE:     next_readdata = {29'h0, irq_enable};
			default:            next_readdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (bus_rd_take) begin
			avs_readdata <= next_readdata;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	AST_IDLE_LOAD: assert property (state == ST_EXEC && op_idle && !reset_evt // RQ1
		|=> standby_left == timeout_ticks($past(cmd_sc)) && standby_reload == standby_left && pwr == PWR_IDLE)
		else $error("idle did not load the standby timer");
	AST_SKIP_SPINUP: assert property (state == ST_EXEC && (op_idle || op_imm) && speed_s && !reset_evt // RQ2
		|=> state == ST_DONE && spindle_run)
		else $error("spin-up not skipped while at speed");
	AST_SPIN_WAIT: assert property (state == ST_EXEC && (op_idle || op_imm) && !speed_s && !reset_evt // RQ9
		|=> state == ST_SPIN && spindle_run)
		else $error("idle entry did not wait for spindle");
	AST_ZERO_DISABLES: assert property (pwr == PWR_IDLE && standby_reload == 16'h0000 && state == ST_READY // RQ3
		&& !cmd_go |=> pwr == PWR_IDLE)
		else $error("standby entered with timer disabled");
	AST_HALF_HOUR: assert property (state == ST_EXEC && op_idle && cmd_sc == 8'd241 && !reset_evt // RQ4
		|=> standby_reload == 16'd360)
		else $error("value 241 is not thirty minutes");
	AST_EIGHT_HOURS: assert property (state == ST_EXEC && op_idle && cmd_sc == 8'd253 && !reset_evt // RQ5
		|=> standby_reload == 16'd5760)
		else $error("value 253 is not eight hours");
	AST_STANDBY: assert property (pwr == PWR_IDLE && standby_reload != 16'h0000 && standby_left == 16'h0000 // RQ6
		&& state == ST_READY && !host_access |=> pwr == PWR_STANDBY && !spindle_run && irq_status[IRQ_STANDBY_BIT])
		else $error("expiry did not enter standby");
	AST_RESTART: assert property (host_access && !(state == ST_EXEC && op_idle) // RQ7
		|=> standby_left == $past(standby_reload))
		else $error("host access did not restart the interval");
	AST_IMM_KEEPS: assert property (state == ST_EXEC && op_imm |=> $stable(standby_reload)) // RQ8
		else $error("idle immediate changed the timer value");
	AST_GEOM_SET: assert property (state == ST_EXEC && op_init && !reset_evt // RQ10
		|=> geom.spt == $past(cmd_sc) && geom.heads_m1 == $past(cmd_head))
		else $error("geometry not taken from the command");
	AST_GEOM_HOLD: assert property (reset_evt && !feat_opt[OPT_REVERT_BIT] |=> $stable(geom)) // RQ13
		else $error("geometry lost on non-reverting reset");
	AST_CHECKSUM: assert property (word255[7:0] == ID_SIGNATURE // RQ16
		&& 8'(ident_sum[7:0] + {4'h0, geom.heads_m1} + 8'h01 + geom.spt + {4'h0, feat_opt} + ID_SIGNATURE
		+ word255[15:8]) == 8'h00)
		else $error("identify word 255 is wrong");
	AST_ABORT: assert property (state == ST_EXEC && !(op_idle || op_imm || op_init) && !reset_evt // RQ17
		|=> error_flags[ERR_ABT_BIT] && err ##1 state == ST_READY && !command_status[ST_BSY_BIT])
		else $error("unsupported command not aborted");
	AST_IMM_IDLE: assert property (state == ST_EXEC && op_imm // RQ8
		|=> pwr == PWR_IDLE && spindle_run)
		else $error("idle immediate did not enter idle");
	AST_ZERO_SPT: assert property (state == ST_EXEC && op_init && cmd_sc == 8'h00 && !reset_evt // RQ11
		|=> geom.spt == 8'h00)
		else $error("zero sectors per track not kept as zero");
	AST_HEAD_FIELD: assert property (cmd_go && !reset_evt // RQ12
		|=> cmd_head == $past(device_head[3:0]))
		else $error("head field not latched from the low nibble");
	AST_REVERT: assert property (reset_evt && feat_opt[OPT_REVERT_BIT] // RQ13
		|=> geom.spt == RST_SPT && geom.heads_m1 == RST_HEADS_M1)
		else $error("reverting reset did not restore geometry");
	AST_BUSY_START: assert property (cmd_go && !reset_evt // RQ17
		|=> command_status[ST_BSY_BIT] && !command_status[ST_RDY_BIT])
		else $error("accepted command did not raise busy");
	AST_BUSY_END: assert property (state == ST_DONE // RQ17
		|=> !command_status[ST_BSY_BIT])
		else $error("busy not cleared at command end");

	COV_IDLE_SPIN: cover property (state == ST_SPIN ##1 state == ST_DONE);
	COV_STANDBY: cover property (pwr == PWR_IDLE ##1 pwr == PWR_STANDBY);
	COV_GEOM: cover property (state == ST_EXEC && op_init);
	COV_ABORT: cover property (state == ST_DONE && err);
	COV_RESTART: cover property (host_access && pwr == PWR_IDLE && standby_left != standby_reload);

endmodule

//--- dv/spindle_model.sv
// behavioural spindle motor that reaches speed a fixed time after it is commanded on
`timescale 1ns/100ps

module spindle_model #(
	parameter int SPIN_CYCLES = 20
) (
	// clock
	input  wire logic ref_clk,
	// motor command and speed sense
	input  wire logic spindle_run,
	output logic      spindle_at_speed
);
	int cnt = 0;

	// spin-down is taken as instant so a later idle always needs a real spin-up
	always_ff @(posedge ref_clk) begin
		if (spindle_run !== 1'b1) begin
			cnt <= 0;
		end else if (cnt < SPIN_CYCLES) begin
			cnt <= cnt + 1;
		end
	end

	assign spindle_at_speed = (cnt == SPIN_CYCLES);
endmodule

//--- dv/ata_idle_geom_tb.sv
// self-checking bench for the idle and geometry command block
`timescale 1ns/100ps

module ata_idle_geom_tb import ata_cmd_pkg::*; ;
	localparam int TICK = 64;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        spindle_at_speed;
	logic        hard_reset_n = 1'b1;
	logic        spindle_run;
	logic        irq;
	logic [31:0] rdata;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          np;
	logic [7:0]  tv [8] = '{8'd1, 8'd240, 8'd241, 8'd251, 8'd252, 8'd253, 8'd254, 8'd255};
	logic [15:0] tt [8] = '{16'd1, 16'd240, 16'd360, 16'd3960, 16'd252, 16'd5760, 16'd254, 16'd255};

	always #10 ref_clk = ~ref_clk;

	ata_idle_geom #(.TICK_CYCLES(TICK)) u_dut (
		.ref_clk         (ref_clk),
		.rst             (rst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_byteenable  (avs_byteenable),
		.avs_writedata   (avs_writedata),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.spindle_at_speed(spindle_at_speed),
		.hard_reset_n    (hard_reset_n),
		.spindle_run     (spindle_run),
		.irq             (irq)
	);

	spindle_model u_motor (
		.ref_clk         (ref_clk),
		.spindle_run     (spindle_run),
		.spindle_at_speed(spindle_at_speed)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// request held until the edge that samples waitrequest low, released only after it
	task automatic bus(input logic rw, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= rw;
		avs_read <= !rw;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		rdata = avs_readdata;
		if (n >= 40) chk(32'h0, 32'h1);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic cmd(input logic [7:0] op);
		wr(OFS_COMMAND, {24'h0, op});
		np = 0;
		do begin
			rd(OFS_COMMAND_STATUS);
			np++;
		end while (rdata[ST_BSY_BIT] !== 1'b0 && np < 60);
		chk({31'h0, rdata[ST_BSY_BIT]}, 32'h0);
	endtask

	// timer may already have stepped once by the time the read lands
	task automatic chk_ticks(input logic [15:0] t);
		rd(OFS_POWER);
		chk(rdata[31:16] + 16'(rdata[31:16] != t), t);
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge ref_clk);
		n_mismatch++;
		test_done();
	end

	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		rd(OFS_COMMAND_STATUS);
		chk(rdata & 32'hd1, 32'h40);
		rd(OFS_GEOMETRY);
		chk(rdata, 32'hf3f);
		wr(OFS_IRQ_ENABLE, 32'h2);
		rd(OFS_IRQ_ENABLE);
		chk(rdata, 32'h2);
		// geometry with zero sectors per track; a write without lane 0 must not land
		wr(OFS_SECTOR_COUNT, 32'h0);
		avs_byteenable <= 4'he;
		wr(OFS_SECTOR_COUNT, 32'h77);
		avs_byteenable <= 4'hf;
		rd(OFS_SECTOR_COUNT);
		chk(rdata, 32'h0);
		wr(OFS_DEVICE_HEAD, 32'h5);
		cmd(OP_INIT_PARAMS);
		rd(OFS_GEOMETRY);
		chk(rdata, 32'h500);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_IDENT_SUM, 32'h10);
		rd(OFS_IDENT_W255);
		chk(rdata, 32'h45a5);
		wr(OFS_FEATURE_OPT, 32'hfb);
		rd(OFS_IDENT_W129);
		chk(rdata, 32'hb);
		rd(OFS_IDENT_W255);
		chk(rdata, 32'h3aa5);
		// resets keep geometry unless the reverting option is on
		wr(OFS_SOFT_RESET, 32'h1);
		rd(OFS_GEOMETRY);
		chk(rdata, 32'h500);
		wr(OFS_FEATURE_OPT, 32'h4);
		wr(OFS_SOFT_RESET, 32'h1);
		rd(OFS_GEOMETRY);
		chk(rdata, 32'hf3f);
		wr(OFS_SECTOR_COUNT, 32'hff);
		wr(OFS_DEVICE_HEAD, 32'hff);
		cmd(OP_INIT_PARAMS);
		rd(OFS_GEOMETRY);
		chk(rdata, 32'hfff);
		hard_reset_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		hard_reset_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd(OFS_GEOMETRY);
		chk(rdata, 32'hf3f);
		// unsupported opcode
		cmd(8'h00);
		rd(OFS_ERROR_FLAGS);
		chk(rdata & 32'h4, 32'h4);
		rd(OFS_COMMAND_STATUS);
		chk(rdata & 32'h81, 32'h1);
		rd(OFS_IRQ_STATUS);
		chk(rdata & 32'h3, 32'h3);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_CLEAR, 32'h7);
		rd(OFS_IRQ_STATUS);
		chk(rdata, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// idle from a stopped spindle, then expiry into standby
		wr(OFS_IRQ_ENABLE, 32'h4);
		wr(OFS_SECTOR_COUNT, 32'h2);
		cmd(OP_IDLE_A);
		rd(OFS_COMMAND_STATUS);
		chk(rdata & 32'hd1, 32'h50);
		chk({31'h0, spindle_run}, 32'h1);
		rd(OFS_POWER);
		chk(rdata & 32'h1ff, 32'h101);
		chk_ticks(16'd2);
		repeat (3 * TICK) @(posedge ref_clk);
		rd(OFS_POWER);
		chk(rdata & 32'h3, 32'h0);
		chk({31'h0, spindle_run}, 32'h0);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_IRQ_CLEAR, 32'h7);
		// host accesses keep restarting the interval
		wr(OFS_SECTOR_COUNT, 32'h1);
		cmd(OP_IDLE_B);
		for (int i = 0; i < 8; i++) begin
			repeat (20) @(posedge ref_clk);
			wr(OFS_HOST_ACCESS, 32'h1);
		end
		rd(OFS_POWER);
		chk(rdata & 32'h3, 32'h1);
		cmd(OP_IDLE_B);
		chk(32'(np <= 2), 32'h1);
		repeat (2 * TICK) @(posedge ref_clk);
		rd(OFS_POWER);
		chk(rdata & 32'h3, 32'h0);
		// zero disables the timer; idle immediate leaves it alone
		wr(OFS_SECTOR_COUNT, 32'h0);
		cmd(OP_IDLE_A);
		repeat (3 * TICK) @(posedge ref_clk);
		rd(OFS_POWER);
		chk(rdata & 32'h1ff, 32'h1);
		wr(OFS_SECTOR_COUNT, 32'h5);
		cmd(OP_IDLE_IMM_A);
		rd(OFS_POWER);
		chk(rdata & 32'h1ff, 32'h1);
		wr(OFS_SECTOR_COUNT, 32'h3);
		cmd(OP_IDLE_A);
		wr(OFS_SECTOR_COUNT, 32'h9);
		cmd(OP_IDLE_IMM_B);
		chk_ticks(16'd3);
		cmd(OP_IDLE_IMM_A);
		chk_ticks(16'd3);
		// every timer code class decodes to its interval
		for (int i = 0; i < 8; i++) begin
			wr(OFS_SECTOR_COUNT, {24'h0, tv[i]});
			cmd(OP_IDLE_A);
			chk_ticks(tt[i]);
		end
		test_done();
	end
endmodule
